// file: rtl/mbfsg_pkg.sv
/*
 * mbfsg_pkg: shared types and constants of the masked bit-field scatter/gather unit.
 * Assumes the instruction decode and the accumulator file sit on the same core clock.
 */
package mbfsg_pkg;

   // =====================================================================
   // widths
   // =====================================================================
   localparam int unsigned SRC_W_DEF  = 32;     // source accumulator width
   localparam int unsigned MASK_W_DEF = 16;     // mask width
   localparam int unsigned PTR_W      = 5;      // bit pointers reach 0..16

   // =====================================================================
   // reset values and pointer start
   // =====================================================================
   localparam logic [PTR_W-1:0]  PTR_START = 5'h00;    // both pointers start at bit 0
   localparam logic [31:0]       DST_CLEAR = 32'h0000_0000;
   localparam logic [15:0]       MASK_RST  = 16'h0000;

   // =====================================================================
   // opcodes
   // =====================================================================
   typedef enum logic [0:0] {
      MBFSG_MASK_DEPOSIT_OPCODE = 1'b0,   // spread low source bits under the mask
      MBFSG_MASK_GATHER_OPCODE  = 1'b1    // pack masked source bits to the bottom
   } mbfsg_op_e;

   // =====================================================================
   // carriers
   // =====================================================================
   typedef struct packed {
      logic          valid;
      mbfsg_op_e     op;
      logic [31:0]   source_accumulator;
      logic [15:0]   sixteen_bit_mask;
   } mbfsg_req_s;

   typedef struct packed {
      logic          valid;
      mbfsg_op_e     op;
      logic [31:0]   data;
   } mbfsg_rsp_s;

endpackage

// file: rtl/mbfsg_scan_step.sv
/*
 * mbfsg_scan_step: one mask-bit step of the scan chain, purely combinational.
 * Assumes the caller chains sixteen of these in ascending mask order.
 */
`timescale 1ns/1ps
`default_nettype none

module mbfsg_scan_step
   import mbfsg_pkg::*;
(
   input  wire mbfsg_pkg::mbfsg_op_e op_in,
   input  wire logic                 mask_bit_in,
   input  wire logic [31:0]          src_in,
   input  wire logic [15:0]          dst_in,
   input  wire logic [4:0]           dest_ptr_in,
   input  wire logic [4:0]           src_ptr_in,
   output logic      [15:0]          dst_out,
   output logic      [4:0]           dest_ptr_out,
   output logic      [4:0]           src_ptr_out
);
   import mbfsg_pkg::*;

   // =====================================================================
   // copy on a set mask bit, otherwise move one pointer on
   // =====================================================================
   always_comb begin
      dst_out      = dst_in;
      dest_ptr_out = dest_ptr_in;
      src_ptr_out  = src_ptr_in;
      if (mask_bit_in) begin
         // pointer never tops 15 while a bit is still to be written
         dst_out[dest_ptr_in[3:0]] = src_in[src_ptr_in];
         dest_ptr_out              = dest_ptr_in + 5'h01;
         src_ptr_out               = src_ptr_in + 5'h01;
      end else if (op_in == MBFSG_MASK_DEPOSIT_OPCODE) begin
         dest_ptr_out = dest_ptr_in + 5'h01;
      end else begin
         src_ptr_out  = src_ptr_in + 5'h01;
      end
   end

endmodule

`default_nettype wire

// file: rtl/mbfsg_unit.sv
/*
 * mbfsg_unit: single-cycle mask deposit / mask gather datapath.
 * Assumes requests come from decode on the same clock; no handshake back-pressure.
 */
// How it works
// - a deposit request yields its whole result one clock after it is taken.
// - the result starts all zero and both bit pointers start at bit zero.
// - mask bits are handled one after another from bit 0 up to bit 15.
// - in deposit a set mask bit copies the source bit to the destination and bumps both pointers.
// - in deposit a clear mask bit bumps only the destination pointer.
// - a gather request also yields its result in one clock with the same clearing.
// - in gather a set mask bit copies the source bit to the destination and bumps both pointers.
// - in gather a clear mask bit bumps only the source pointer, skipping that bit.
// - the source is a 32-bit accumulator but only its bits 0 to 15 are ever read, in either operation.
`timescale 1ns/1ps
`default_nettype none

module mbfsg_unit
   import mbfsg_pkg::*;
#(
   parameter int unsigned SRC_W  = mbfsg_pkg::SRC_W_DEF,
   parameter int unsigned MASK_W = mbfsg_pkg::MASK_W_DEF
)(
   input  wire logic                  clk_in,
   input  wire logic                  rstn_in,
   input  wire logic                  ce_in,
   input  wire mbfsg_pkg::mbfsg_req_s req_in,
   output mbfsg_pkg::mbfsg_rsp_s      rsp_out
);
   import mbfsg_pkg::*;

   // =====================================================================
   // elaboration checks
   // =====================================================================
   // the carriers are fixed at 32/16 bits, so other widths cannot be served
   if (SRC_W != 32 || MASK_W != 16) begin : g_bad_width
      $error("mbfsg_unit supports only a 32-bit source and a 16-bit mask");
   end

   // =====================================================================
   // state: one packed struct
   // =====================================================================
   typedef struct packed {
      logic          valid;
      mbfsg_op_e     op;
      logic [31:0]   src;        // captured operands kept for observation
      logic [15:0]   mask;
      logic [31:0]   data;
   } mbfsg_state_s;

   mbfsg_state_s state_r;
   mbfsg_state_s state_nxt;

   // =====================================================================
   // scan chain, ascending mask order
   // =====================================================================
   logic [15:0] dst_chain  [0:16];
   logic [4:0]  dptr_chain [0:16];
   logic [4:0]  sptr_chain [0:16];

   // start cleared with both pointers at bit zero
   assign dst_chain[0]  = DST_CLEAR[15:0];
   assign dptr_chain[0] = PTR_START;
   assign sptr_chain[0] = PTR_START;

   // step k sees the pointers left by step k-1, so bit 0 goes first
   for (genvar k = 0; k < 16; k++) begin : g_scan
      mbfsg_scan_step u_step (
         .op_in        (req_in.op),
         .mask_bit_in  (req_in.sixteen_bit_mask[k]),
         .src_in       (req_in.source_accumulator),
         .dst_in       (dst_chain[k]),
         .dest_ptr_in  (dptr_chain[k]),
         .src_ptr_in   (sptr_chain[k]),
         .dst_out      (dst_chain[k+1]),
         .dest_ptr_out (dptr_chain[k+1]),
         .src_ptr_out  (sptr_chain[k+1])
      );
   end

   // =====================================================================
   // next state
   // =====================================================================
   always_comb begin
      state_nxt       = state_r;
      state_nxt.valid = req_in.valid;
      if (req_in.valid) begin
         state_nxt.op   = req_in.op;
         state_nxt.src  = req_in.source_accumulator;
         state_nxt.mask = req_in.sixteen_bit_mask;
         // upper half never written, stays clear
         state_nxt.data = {16'h0000, dst_chain[16]};
      end
   end

   // =====================================================================
   // state register, frozen while ce is low
   // =====================================================================
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_r <= '{valid: 1'b0, op: MBFSG_MASK_DEPOSIT_OPCODE, src: DST_CLEAR,
                      mask: MASK_RST, data: DST_CLEAR};
      end else if (ce_in) begin
         state_r <= state_nxt;
      end
   end

   // one assignment for the whole carrier keeps a single driver on the output
   assign rsp_out = '{valid: state_r.valid, op: state_r.op, data: state_r.data};

   // =====================================================================
   // assertions
   // =====================================================================
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   function automatic logic [15:0] dep_ref(input logic [31:0] s, input logic [15:0] m);
      logic [4:0]  sp;
      logic [15:0] r;
      sp = 5'h00;
      r  = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         if (m[i]) begin
            r[i] = s[sp];
            sp   = sp + 5'h01;
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] gat_ref(input logic [31:0] s, input logic [15:0] m);
      logic [4:0]  dp;
      logic [15:0] r;
      dp = 5'h00;
      r  = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         if (m[i]) begin
            r[dp[3:0]] = s[i];
            dp         = dp + 5'h01;
         end
      end
      return r;
   endfunction

   sequence s_take;
      ce_in && req_in.valid;
   endsequence

   sequence s_take_dep;
      s_take ##0 (req_in.op == MBFSG_MASK_DEPOSIT_OPCODE);
   endsequence

   sequence s_take_gat;
      s_take ##0 (req_in.op == MBFSG_MASK_GATHER_OPCODE);
   endsequence

   // deposit whose first mask bit is set: bit 0 must come from source bit 0
   sequence s_dep_low;
      s_take_dep ##0 req_in.sixteen_bit_mask[0];
   endsequence

   // gather of the top mask bit alone: fifteen source bits must be skipped
   sequence s_gat_top;
      s_take_gat ##0 (req_in.sixteen_bit_mask == 16'h8000);
   endsequence

   sequence s_take_empty;
      s_take ##0 (req_in.sixteen_bit_mask == 16'h0000);
   endsequence

   // an enabled edge with nothing offered: the answer drops, the result holds
   sequence s_idle;
      ce_in && !req_in.valid;
   endsequence

   one_cycle_result_a: assert property (s_take |=> rsp_out.valid)
      else $error("result not valid one cycle after request");

   deposit_value_a: assert property (s_take_dep |=>
         (rsp_out.data[15:0] == dep_ref(state_r.src, state_r.mask)))
      else $error("deposit result wrong");

   deposit_gaps_a: assert property (s_take_dep |=>
         ((rsp_out.data[15:0] & ~state_r.mask) == 16'h0000))
      else $error("deposit wrote an unselected position");

   gather_value_a: assert property (s_take_gat |=>
         (rsp_out.data[15:0] == gat_ref(state_r.src, state_r.mask)))
      else $error("gather result wrong");

   gather_top_clear_a: assert property (s_take_gat |=>
         ((rsp_out.data[15:0] >> $countones(state_r.mask)) == 16'h0000))
      else $error("gather wrote beyond the selected count");

   // a gather moves each selected bit once and nothing else, so the ones count is kept
   gather_ones_a: assert property (s_take_gat |=>
         ($countones(rsp_out.data) == $countones(state_r.src[15:0] & state_r.mask)))
      else $error("gather lost or invented a set bit");

   lowest_bit_order_a: assert property (s_dep_low |=>
         rsp_out.data[0] == state_r.src[0])
      else $error("first mask bit did not take source bit 0");

   upper_half_zero_a: assert property (rsp_out.valid |->
         rsp_out.data[31:16] == 16'h0000)
      else $error("upper result bits not clear");

   gather_skip_a: assert property (s_gat_top |=>
         rsp_out.data == {31'h0000_0000, state_r.src[15]})
      else $error("gather did not skip unselected bits");

   hold_on_ce_low_a: assert property (!ce_in |=> $stable(rsp_out))
      else $error("state moved while clock enable low");

   empty_mask_zero_a: assert property (s_take_empty |=>
         rsp_out.data == 32'h0000_0000)
      else $error("empty mask gave a non-zero result");

   // the answer is a one-cycle strobe; a stuck valid would double-count a result
   valid_drop_a: assert property (s_idle |=> !rsp_out.valid)
      else $error("result valid without a request");

   data_hold_a: assert property (s_idle |=> $stable(rsp_out.data))
      else $error("result data moved without a request");

   op_echo_a: assert property (s_take |=> rsp_out.op == $past(req_in.op))
      else $error("answered operation differs from the request");

endmodule

`default_nettype wire

// file: sim/mbfsg_decode_model.sv
/* mbfsg_decode_model: stand-in for decode and the accumulator file.
   Assumes the bench calls its tasks at the falling clock edge. */
`timescale 1ns/1ps
`default_nettype none
module mbfsg_decode_model (
   output var mbfsg_pkg::mbfsg_req_s req_out
);
   import mbfsg_pkg::*;
   // =====================================================
   // request drive
   // =====================================================
   initial req_out = '0;
   // one request per call; the caller owns the edge timing
   task automatic drive(input mbfsg_op_e op, input logic [31:0] src,
                        input logic [15:0] mask);
      req_out = {1'b1, op, src, mask};
   endtask
   // released operands flip so stale data never looks valid
   task automatic release_bus();
      req_out = {1'b0, req_out.op, ~req_out.source_accumulator,
                 ~req_out.sixteen_bit_mask};
   endtask
   // encoder output: stream xor its copies shifted by 3 and 4
   function automatic logic [31:0] encode_g0(input logic [31:0] x);
      return x ^ (x >> 3) ^ (x >> 4);
   endfunction
endmodule
`default_nettype wire

// file: sim/mbfsg_unit_tb_top.sv
/* mbfsg_unit_tb_top: self-checking bench of the scatter/gather unit.
   Assumes the decode model drives requests; 100 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module mbfsg_unit_tb_top;
   import mbfsg_pkg::*;
   logic       clk_in;
   logic       rstn_in;
   logic       ce_in;
   mbfsg_req_s req;
   mbfsg_rsp_s rsp_out;
   logic [33:0] last_exp;
   int         miscompares;
   int         comparisons;
   // =====================================================
   // clock, design and partner
   // =====================================================
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   mbfsg_unit dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
                   .req_in(req), .rsp_out(rsp_out));
   mbfsg_decode_model dec (.req_out(req));
   // =====================================================
   // reference and checking
   // =====================================================
   // own scan model: cleared result, both pointers from zero
   function automatic logic [31:0] ref_op(input logic op, input logic [31:0] s,
                                          input logic [15:0] m);
      logic [31:0] d;
      int          p;
      d = 32'h0;
      p = 0;
      for (int i = 0; i < 16; i++) begin
         if (m[i]) begin
            if (op) d[p] = s[i];
            else d[i] = s[p];
            p++;
         end
      end
      return d;
   endfunction
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: rsp %h expected %h", $time, seen, exp);
      end
   endtask
   // one request, answer checked one edge later
   task automatic op1(input logic op, input logic [31:0] s, input logic [15:0] m,
                      input logic [31:0] exp);
      dec.drive(mbfsg_op_e'(op), s, m);
      @(negedge clk_in);
      check(rsp_out, {1'b1, op, exp});
      last_exp = {1'b0, op, exp};
   endtask
   // valid must fall while op and data hold
   task automatic idle_chk();
      dec.release_bus();
      @(negedge clk_in);
      check(rsp_out, last_exp);
   endtask
   // =====================================================
   // scenarios
   // =====================================================
   // back-to-back ops over edge and sparse masks
   task automatic t_run(input logic op);
      logic [15:0] mk [7] = '{16'h0000, 16'hffff, 16'h5555, 16'haaaa,
                              16'h8001, 16'h7ff0, 16'h8000};
      logic [31:0] sv [7] = '{32'hffff_ffff, 32'h1234_a5c3, 32'h8000_00ff,
                              32'hc0de_9a5c, 32'h0001_8001, 32'hfedc_0f37,
                              32'h5555_8001};
      for (int i = 0; i < 7; i++) begin
         op1(op, sv[i], mk[i], ref_op(op, sv[i], mk[i]));
      end
      idle_chk();
      $display("test run op %0d done", op);
   endtask
   // software interleave of two encoder streams, then split back
   task automatic t_interleave();
      logic [31:0] g0;
      logic [31:0] g1;
      logic [31:0] mux;
      g0 = dec.encode_g0(32'h0000_9a5c);
      g1 = dec.encode_g0(32'h0000_63e1);
      mux = ref_op(1'b0, g0, 16'h5555) | ref_op(1'b0, g1, 16'haaaa);
      op1(1'b0, g0, 16'h5555, ref_op(1'b0, g0, 16'h5555));
      op1(1'b0, g1, 16'haaaa, ref_op(1'b0, g1, 16'haaaa));
      op1(1'b1, mux, 16'h5555, {24'h0, g0[7:0]});
      op1(1'b1, mux, 16'haaaa, {24'h0, g1[7:0]});
      idle_chk();
      $display("test interleave done");
   endtask
   // clock enable low holds a pending request and the outputs
   task automatic t_ce();
      ce_in = 1'b0;
      dec.drive(MBFSG_MASK_GATHER_OPCODE, 32'h0000_f0f0, 16'hff00);
      repeat (2) @(negedge clk_in);
      check(rsp_out, last_exp);
      ce_in = 1'b1;
      @(negedge clk_in);
      check(rsp_out, {2'b11, 32'h0000_00f0});
      last_exp = {2'b01, 32'h0000_00f0};
      idle_chk();
      $display("test clock enable done");
   endtask
   // =====================================================
   // run control
   // =====================================================
   task automatic final_report();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // about thirty cycles of work; far longer means a hang
   initial begin
      #5000;
      miscompares++;
      final_report();
   end
   initial begin
      ce_in = 1'b1;
      rstn_in = 1'b0;
      miscompares = 0;
      comparisons = 0;
      repeat (4) @(negedge clk_in);
      rstn_in = 1'b1;
      @(negedge clk_in);
      check(rsp_out, 34'h0);
      t_run(1'b0);
      t_run(1'b1);
      t_interleave();
      t_ce();
      final_report();
   end
endmodule
`default_nettype wire
